// ===== design/dtc_map.svh
// register indices, field positions, reset values and counts of the timers
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// register index; byte address is four times the index
`define DTC_IDX_TIMER_CONTROL     8'h88
`define DTC_IDX_TIMER_MODE        8'h89
`define DTC_IDX_COUNTER0_LOW      8'h8a
`define DTC_IDX_COUNTER1_LOW      8'h8b
`define DTC_IDX_COUNTER0_HIGH     8'h8c
`define DTC_IDX_COUNTER1_HIGH     8'h8d
`define DTC_IDX_IRQ_STATUS        8'h90
`define DTC_IDX_IRQ_MASK          8'h91

// timer_control fields
`define DTC_TC_OVF1               7
`define DTC_TC_RUN1               6
`define DTC_TC_OVF0               5
`define DTC_TC_RUN0               4
`define DTC_TC_PEND1              3
`define DTC_TC_TYPE1              2
`define DTC_TC_PEND0              1
`define DTC_TC_TYPE0              0

// timer_mode fields, timer 1 in the upper nibble
`define DTC_TM_GATE               3
`define DTC_TM_CT                 2
`define DTC_TM_HI                 1
`define DTC_TM_LO                 0
`define DTC_TM_T1_BASE            4

// irq_status and irq_mask fields
`define DTC_IS_OVF0               0
`define DTC_IS_OVF1               1
`define DTC_IS_EXT0               2
`define DTC_IS_EXT1               3

`define DTC_RST_BYTE              8'h00
`define DTC_RST_IRQ               4'h0

// oscillator clocks per internal count
`define DTC_PRESCALE_DIV          12

`endif

// ===== design/dtc_pkg.sv
// types shared by the dual timer/counter block
package dtc_pkg;

	typedef enum logic [1:0] {
		DTC_MODE_PRESC,
		DTC_MODE_FULL,
		DTC_MODE_RELOAD,
		DTC_MODE_SPLIT
	} dtc_mode_t;

	typedef struct packed {
		logic [1:0] ext_irq_pin;
		logic [1:0] count_input_pin;
	} dtc_pins_t;

	typedef struct packed {
		logic [1:0] timer;
		logic [1:0] ext;
	} dtc_ack_t;

	typedef struct packed {
		logic       carry;
		logic [7:0] high;
		logic [7:0] low;
	} dtc_cnt_t;

endpackage : dtc_pkg

// ===== design/dtc_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module dtc_sync #(
	parameter int         WIDTH     = 1,
	parameter logic [0:0] RESET_VAL = 1'b1
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, q_reg;
	logic [WIDTH-1:0] q_next;

	// the level moves only once stages two and three agree
	always_comb begin
		q_next = q_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_reg[i] == s3_reg[i]) begin
				q_next[i] = s3_reg[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= {WIDTH{RESET_VAL}};
			s2_reg <= {WIDTH{RESET_VAL}};
			s3_reg <= {WIDTH{RESET_VAL}};
			q_reg  <= {WIDTH{RESET_VAL}};
		end else if (ce) begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg  <= q_next;
		end
	end

	assign q = q_reg;
endmodule : dtc_sync

// ===== design/dtc_top.sv
// dual 16-bit timer/counter with external interrupt detection, APB slave
`timescale 1ns/1ps
`include "dtc_map.svh"
module dtc_top #(
	parameter int ADDR_W = 12
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              ce,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire dtc_pkg::dtc_pins_t pins,
	input  wire dtc_pkg::dtc_ack_t  ack,
	output logic                   irq
);
	import dtc_pkg::*;

	logic [7:0]  timer_control_reg, timer_control_next, timer_mode_reg, timer_mode_next;
	logic [7:0]  tl0_reg, tl0_next, th0_reg, th0_next;
	logic [7:0]  tl1_reg, tl1_next, th1_reg, th1_next;
	logic [3:0]  st_reg, st_next, mask_reg, mask_next;
	logic [31:0] prdata_reg, prdata_next;
	logic [3:0]  presc_reg, presc_next;
	logic [3:0]  pin_prev_reg, pin_prev_next;
	logic [3:0]  pin_f;
	logic [7:0]  idx;
	logic        acc, wr, hit;
	logic        wr_timer_control, wr_timer_mode, wr_tl0, wr_th0, wr_tl1, wr_th1;
	logic        presc_tick;
	logic [1:0]  x_lvl, c_lvl, x_fall, c_fall;
	logic [3:0]  tm0, tm1;
	dtc_mode_t   mode0, mode1;
	logic        run0, run1, inc0, inc1, inc0_hi;
	dtc_cnt_t    step0, step1, step0_hi;
	logic        carry0, carry1;
	logic [1:0]  pend_set;
	logic [3:0]  evt;
	logic [31:0] rd_mux;

	// pins: {ext1, ext0, count1, count0}
	dtc_sync #(
		.WIDTH     (4),
		.RESET_VAL (1'b1)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.d       ({pins.ext_irq_pin, pins.count_input_pin}),
		.q       (pin_f)
	);

	assign x_lvl  = pin_f[3:2];
	assign c_lvl  = pin_f[1:0];
	assign x_fall = pin_prev_reg[3:2] & ~x_lvl;
	assign c_fall = pin_prev_reg[1:0] & ~c_lvl;

	// one counting step of a timer in modes 00, 01, 10 and 11
	function automatic dtc_cnt_t step(input dtc_mode_t m, input logic [7:0] lo,
			input logic [7:0] hi, input logic inc);
		dtc_cnt_t r;
		logic [12:0] p13;
		r = '{carry: 1'b0, high: hi, low: lo};
		p13 = {hi, lo[4:0]} + 13'h0001;
		if (inc) begin
			case (m)
			DTC_MODE_PRESC: begin
				r.carry = &{hi, lo[4:0]};
				r.high  = p13[12:5];
				r.low   = {lo[7:5], p13[4:0]};
			end
			DTC_MODE_FULL: begin
				r.carry = &{hi, lo};
				{r.high, r.low} = {hi, lo} + 16'h0001;
			end
			DTC_MODE_RELOAD: begin
				r.carry = &lo;
				r.low   = (&lo) ? hi : lo + 8'h01;
			end
			default: begin
				r.carry = &lo;
				r.low   = lo + 8'h01;
			end
			endcase
		end
		return r;
	endfunction : step

	// bus decode; pready follows ce so frozen cycles stall the master
	assign idx     = paddr[9:2];
	assign acc     = psel & penable;
	assign wr      = acc & pwrite & ce;
	assign hit     = (paddr[1:0] == 2'b00) && ((idx >= `DTC_IDX_TIMER_CONTROL
			&& idx <= `DTC_IDX_COUNTER1_HIGH) || idx == `DTC_IDX_IRQ_STATUS
			|| idx == `DTC_IDX_IRQ_MASK);
	assign pready  = ce;
	assign pslverr = acc & ~hit;
	assign wr_timer_control = wr && idx == `DTC_IDX_TIMER_CONTROL;
	assign wr_timer_mode = wr && idx == `DTC_IDX_TIMER_MODE;
	assign wr_tl0  = wr && idx == `DTC_IDX_COUNTER0_LOW;
	assign wr_th0  = wr && idx == `DTC_IDX_COUNTER0_HIGH;
	assign wr_tl1  = wr && idx == `DTC_IDX_COUNTER1_LOW;
	assign wr_th1  = wr && idx == `DTC_IDX_COUNTER1_HIGH;

	// counting conditions
	assign tm0   = timer_mode_reg[3:0];
	assign tm1   = timer_mode_reg[7:4];
	assign mode0 = dtc_mode_t'(tm0[`DTC_TM_HI:`DTC_TM_LO]);
	assign mode1 = dtc_mode_t'(tm1[`DTC_TM_HI:`DTC_TM_LO]);
	assign presc_tick = (presc_reg == 4'(`DTC_PRESCALE_DIV - 1));
	assign run0  = timer_control_reg[`DTC_TC_RUN0]
			& (~tm0[`DTC_TM_GATE] | x_lvl[0]);
	assign run1  = timer_control_reg[`DTC_TC_RUN1]
			& (~tm1[`DTC_TM_GATE] | x_lvl[1]);
	assign inc0  = run0 & (tm0[`DTC_TM_CT] ? c_fall[0] : presc_tick);
	assign inc1  = run1 & (tm1[`DTC_TM_CT] ? c_fall[1] : presc_tick)
			& (mode1 != DTC_MODE_SPLIT);
	// in split mode the high byte of counter 0 borrows run control 1
	assign inc0_hi = timer_control_reg[`DTC_TC_RUN1] & presc_tick;
	assign step0    = step(mode0, tl0_reg, th0_reg, inc0);
	assign step0_hi = step(DTC_MODE_SPLIT, th0_reg, 8'h00, inc0_hi);
	assign step1    = step(mode1, tl1_reg, th1_reg, inc1);
	assign carry0 = step0.carry;
	assign carry1 = (mode0 == DTC_MODE_SPLIT) ? step0_hi.carry
			: step1.carry;

	always_comb begin
		presc_next = presc_tick ? 4'h0 : presc_reg + 4'h1;
		pin_prev_next = pin_f;
		timer_mode_next = wr_timer_mode ? pwdata[7:0] : timer_mode_reg;
		tl0_next = wr_tl0 ? pwdata[7:0] : step0.low;
		th0_next = wr_th0 ? pwdata[7:0]
				: (mode0 == DTC_MODE_SPLIT) ? step0_hi.low : step0.high;
		tl1_next = wr_tl1 ? pwdata[7:0] : step1.low;
		th1_next = wr_th1 ? pwdata[7:0] : step1.high;
	end

	// timer_control: run and type bits plain, flags set wins over clear
	always_comb begin
		timer_control_next = wr_timer_control ? pwdata[7:0] : timer_control_reg;
		if (ack.timer[0]) timer_control_next[`DTC_TC_OVF0] = 1'b0;
		if (ack.timer[1]) timer_control_next[`DTC_TC_OVF1] = 1'b0;
		if (carry0) timer_control_next[`DTC_TC_OVF0] = 1'b1;
		if (carry1) timer_control_next[`DTC_TC_OVF1] = 1'b1;
		pend_set = 2'b00;
		for (int i = 0; i < 2; i++) begin
			if (timer_control_reg[`DTC_TC_TYPE0 + 2 * i]) begin
				if (ack.ext[i]) timer_control_next[`DTC_TC_PEND0 + 2 * i] = 1'b0;
				pend_set[i] = x_fall[i];
				if (x_fall[i]) timer_control_next[`DTC_TC_PEND0 + 2 * i] = 1'b1;
			end else begin
				pend_set[i] = ~x_lvl[i] & ~timer_control_reg[`DTC_TC_PEND0 + 2 * i];
				timer_control_next[`DTC_TC_PEND0 + 2 * i] = ~x_lvl[i];
			end
		end
	end

	// sticky status, write one to clear, events win
	always_comb begin
		evt = '0;
		evt[`DTC_IS_OVF0] = carry0;
		evt[`DTC_IS_OVF1] = carry1;
		evt[`DTC_IS_EXT0] = pend_set[0];
		evt[`DTC_IS_EXT1] = pend_set[1];
		st_next = st_reg;
		if (wr && idx == `DTC_IDX_IRQ_STATUS) st_next = st_reg & ~pwdata[3:0];
		st_next = st_next | evt;
		mask_next = (wr && idx == `DTC_IDX_IRQ_MASK) ? pwdata[3:0] : mask_reg;
	end

	// read data is refreshed every cycle with ce high of a selected read transfer
	always_comb begin
		case (idx)
		`DTC_IDX_TIMER_CONTROL: rd_mux = {24'h000000, timer_control_reg};
		`DTC_IDX_TIMER_MODE:    rd_mux = {24'h000000, timer_mode_reg};
		`DTC_IDX_COUNTER0_LOW:  rd_mux = {24'h000000, tl0_reg};
		`DTC_IDX_COUNTER1_LOW:  rd_mux = {24'h000000, tl1_reg};
		`DTC_IDX_COUNTER0_HIGH: rd_mux = {24'h000000, th0_reg};
		`DTC_IDX_COUNTER1_HIGH: rd_mux = {24'h000000, th1_reg};
		`DTC_IDX_IRQ_STATUS:    rd_mux = {28'h0000000, st_reg};
		`DTC_IDX_IRQ_MASK:      rd_mux = {28'h0000000, mask_reg};
		default:                rd_mux = 32'h00000000;
		endcase
		if (paddr[1:0] != 2'b00) rd_mux = 32'h00000000;
		prdata_next = (psel && !pwrite) ? rd_mux : prdata_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control_reg     <= `DTC_RST_BYTE;
			timer_mode_reg     <= `DTC_RST_BYTE;
			tl0_reg      <= `DTC_RST_BYTE;
			th0_reg      <= `DTC_RST_BYTE;
			tl1_reg      <= `DTC_RST_BYTE;
			th1_reg      <= `DTC_RST_BYTE;
			st_reg       <= `DTC_RST_IRQ;
			mask_reg     <= `DTC_RST_IRQ;
			presc_reg    <= 4'h0;
			pin_prev_reg <= 4'hf;
			prdata_reg   <= 32'h00000000;
		end else if (ce) begin
			timer_control_reg     <= timer_control_next;
			timer_mode_reg     <= timer_mode_next;
			tl0_reg      <= tl0_next;
			th0_reg      <= th0_next;
			tl1_reg      <= tl1_next;
			th1_reg      <= th1_next;
			st_reg       <= st_next;
			mask_reg     <= mask_next;
			presc_reg    <= presc_next;
			pin_prev_reg <= pin_prev_next;
			prdata_reg   <= prdata_next;
		end
	end

	assign prdata = prdata_reg;
	assign irq    = |(st_reg & mask_reg);

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic no_cnt_wr, no_cnt1_wr;
	assign no_cnt_wr  = !(wr_tl0 || wr_th0 || wr_timer_mode);
	assign no_cnt1_wr = !(wr_tl1 || wr_th1 || wr_timer_mode);

	property p_gate_hold;
		ce && tm1[`DTC_TM_GATE] && !x_lvl[1] && mode1 != DTC_MODE_SPLIT
			&& no_cnt1_wr
			|=> {th1_reg, tl1_reg} == $past({th1_reg, tl1_reg});
	endproperty
	a_gate_hold: assert property (p_gate_hold)
		else $error("counter 1 moved while its gate pin was low");

	// a frozen cycle stretches the period, so such attempts are dropped
	sequence s_tick_gap;
		(!presc_tick) [*8];
	endsequence
	property p_presc_period;
		disable iff (!presetn || !ce)
		presc_tick |=> s_tick_gap ##1 (!presc_tick) [*3] ##1 presc_tick;
	endproperty
	a_presc_period: assert property (p_presc_period)
		else $error("prescaler tick not on every twelfth clock");

	property p_ext_count;
		ce && tm1[`DTC_TM_CT] && run1 && c_fall[1] && mode1 == DTC_MODE_FULL
			&& no_cnt1_wr |=> {th1_reg, tl1_reg}
			== $past({th1_reg, tl1_reg}) + 16'h0001;
	endproperty
	a_ext_count: assert property (p_ext_count)
		else $error("counter 1 missed a count pin falling edge");

	property p_run_stop;
		ce && !timer_control_reg[`DTC_TC_RUN1] && !wr_tl1 && !wr_th1 && !wr_timer_mode
			|=> {th1_reg, tl1_reg} == $past({th1_reg, tl1_reg});
	endproperty
	a_run_stop: assert property (p_run_stop)
		else $error("counter 1 moved with its run bit clear");

	property p_ovf_set;
		ce && carry0 |=> timer_control_reg[`DTC_TC_OVF0];
	endproperty
	a_ovf_set: assert property (p_ovf_set)
		else $error("overflow flag 0 not set on carry");

	property p_ovf_ack;
		ce && ack.timer[1] && !carry1 && !wr_timer_control |=> !timer_control_reg[`DTC_TC_OVF1];
	endproperty
	a_ovf_ack: assert property (p_ovf_ack)
		else $error("overflow flag 1 not cleared by service");

	property p_ext_level;
		ce && !timer_control_reg[`DTC_TC_TYPE0] && !wr_timer_control
			|=> timer_control_reg[`DTC_TC_PEND0] == !$past(x_lvl[0]);
	endproperty
	a_ext_level: assert property (p_ext_level)
		else $error("level pending flag 0 does not follow the pin");

	property p_ext_edge;
		ce && timer_control_reg[`DTC_TC_TYPE0] && x_fall[0] |=> timer_control_reg[`DTC_TC_PEND0];
	endproperty
	a_ext_edge: assert property (p_ext_edge)
		else $error("falling edge did not set pending flag 0");

	property p_reload;
		ce && mode0 == DTC_MODE_RELOAD && inc0 && tl0_reg == 8'hff && no_cnt_wr
			|=> tl0_reg == $past(th0_reg) && timer_control_reg[`DTC_TC_OVF0];
	endproperty
	a_reload: assert property (p_reload)
		else $error("auto-reload did not load the high byte");

endmodule : dtc_top

// ===== dv/dtc_pins_model.sv
// pin-side model: count pins and interrupt pins, pulled up when idle
`timescale 1ns/1ps
module dtc_pins_model (
	input  wire logic          pclk,
	output dtc_pkg::dtc_pins_t pins
);
	import dtc_pkg::*;

	initial pins = '1;

	// each level held six clocks so the input filter settles
	task automatic cnt(input int ch, input int n);
		repeat (n) begin
			repeat (6) @(posedge pclk);
			pins.count_input_pin[ch] <= 1'h0;
			repeat (6) @(posedge pclk);
			pins.count_input_pin[ch] <= 1'h1;
		end
		repeat (6) @(posedge pclk);
	endtask : cnt

	task automatic irq_pin(input int ch, input logic v);
		@(posedge pclk);
		pins.ext_irq_pin[ch] <= v;
		repeat (8) @(posedge pclk);
	endtask : irq_pin
endmodule : dtc_pins_model

// ===== dv/dtc_top_tb.sv
// self-checking bench for the dual timer/counter
`timescale 1ns/1ps
`include "dtc_map.svh"
module dtc_top_tb;
	import dtc_pkg::*;
	localparam logic [7:0] CTL = `DTC_IDX_TIMER_CONTROL;
	localparam logic [7:0] MOD = `DTC_IDX_TIMER_MODE;
	localparam logic [7:0] L0  = `DTC_IDX_COUNTER0_LOW;
	localparam logic [7:0] L1  = `DTC_IDX_COUNTER1_LOW;
	localparam logic [7:0] H0  = `DTC_IDX_COUNTER0_HIGH;
	localparam logic [7:0] H1  = `DTC_IDX_COUNTER1_HIGH;
	localparam logic [7:0] STS = `DTC_IDX_IRQ_STATUS;
	localparam logic [7:0] MSK = `DTC_IDX_IRQ_MASK;
	logic        pclk, presetn, ce, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, irq, err;
	dtc_pins_t   pins;
	dtc_ack_t    ack;
	int          bad_count, compares;
	realtime     t0;

	dtc_top dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins), .ack(ack), .irq(irq));
	dtc_pins_model model (.pclk(pclk), .pins(pins));

	task automatic summarize;
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] idx,
			input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
			if (n > 20) begin
				bad_count++;
				summarize();
			end
		end while (pready !== 1'h1);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// let the transfer's effects settle before the caller looks
		@(negedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		apb(1'h1, idx, d);
	endtask : wr

	task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
		apb(1'h0, idx, 32'h0);
		chk(rd, e);
	endtask : rdc

	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'h1) begin
			@(negedge pclk);
			n++;
			if (n > 200) begin
				bad_count++;
				summarize();
			end
		end
	endtask : wait_irq

	task automatic pulse_ack(input dtc_ack_t a);
		@(posedge pclk);
		ack <= a;
		@(posedge pclk);
		ack <= '0;
	endtask : pulse_ack

	task automatic t_reset;
		for (int i = 0; i < 6; i++)
			rdc(8'(CTL + i), 32'h0);
		rdc(STS, 32'h0);
		rdc(MSK, 32'h0);
		apb(1'h0, 8'h80, 32'h0);
		chk({31'h0, err}, 32'h1);
	endtask : t_reset

	// reload from ff every tick: overflow spacing is the prescale period
	task automatic t_tick;
		wr(MSK, 32'h1);
		wr(MOD, 32'h02);
		wr(H0, 32'hff);
		wr(L0, 32'hff);
		wr(CTL, 32'h10);
		wait_irq();
		t0 = $realtime;
		wr(STS, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wait_irq();
		chk(32'(int'(($realtime - t0) / 100.0)), 32'd12);
		rdc(CTL, 32'h30);
		wr(CTL, 32'hb0);
		pulse_ack('{timer: 2'h3, ext: 2'h0});
		rdc(CTL, 32'h10);
		wr(MSK, 32'h0);
	endtask : t_tick

	task automatic t_pin;
		wr(MOD, 32'h50);
		wr(L1, 32'hfe);
		wr(H1, 32'h00);
		wr(CTL, 32'h40);
		model.cnt(1, 3);
		rdc(L1, 32'h01);
		rdc(H1, 32'h01);
		@(posedge pclk);
		ce <= 1'h0;
		model.cnt(1, 2);
		ce <= 1'h1;
		rdc(L1, 32'h01);
		wr(CTL, 32'h00);
		model.cnt(1, 2);
		rdc(L1, 32'h01);
		wr(MOD, 32'hd0);
		wr(CTL, 32'h40);
		model.irq_pin(1, 1'h0);
		model.cnt(1, 2);
		rdc(L1, 32'h01);
		model.irq_pin(1, 1'h1);
		model.cnt(1, 2);
		rdc(L1, 32'h03);
		wr(MOD, 32'h04);
		wr(L0, 32'hff);
		wr(H0, 32'h00);
		wr(CTL, 32'h10);
		model.cnt(0, 1);
		rdc(L0, 32'he0);
		rdc(H0, 32'h01);
		wr(MOD, 32'h06);
		wr(H0, 32'hf0);
		wr(L0, 32'hfe);
		model.cnt(0, 3);
		rdc(L0, 32'hf1);
		wr(MOD, 32'h07);
		wr(CTL, 32'h10);
		wr(L0, 32'hff);
		model.cnt(0, 1);
		rdc(L0, 32'h00);
		rdc(H0, 32'hf0);
		rdc(CTL, 32'h30);
	endtask : t_pin

	task automatic t_ext;
		wr(CTL, 32'h00);
		model.irq_pin(0, 1'h0);
		rdc(CTL, 32'h02);
		model.irq_pin(0, 1'h1);
		rdc(CTL, 32'h00);
		wr(STS, 32'hf);
		wr(MSK, 32'h4);
		wr(CTL, 32'h01);
		model.irq_pin(0, 1'h0);
		model.irq_pin(0, 1'h1);
		rdc(CTL, 32'h03);
		chk({31'h0, irq}, 32'h1);
		wr(MSK, 32'h0);
		chk({31'h0, irq}, 32'h0);
		pulse_ack('{timer: 2'h0, ext: 2'h1});
		rdc(CTL, 32'h01);
		wr(STS, 32'h4);
		rdc(STS, 32'h0);
	endtask : t_ext

	initial begin
		pclk = 1'h0;
		forever #50 pclk = ~pclk;
	end

	initial begin
		presetn = 1'h0;
		ce = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		ack = '0;
		bad_count = 0;
		compares = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_tick();
		t_pin();
		t_ext();
		summarize();
	end
endmodule : dtc_top_tb
